// *** verilog/ls_align_pkg.sv ***
// What this block does
// - drive link good once bytes are aligned within and across all active lanes
// - restart alignment on lock loss, sync or signal loss, config change, reset, errors
// - send a repeating 49-character pattern on all enabled lanes together
// - each lane has its own 8b/10b encoder, all running in parallel
// - twelve fixed data characters, control flag 0, sent four times in order
// - once link-good input is high, stop pattern and forward high-speed traffic
// - receiver deskews either two or four lanes
// - lane deskew uses the comma character as its marker
// - lock each lane by rotating byte boundaries, then restore order across lanes
// - after alignment, stop checking deskew and carry normal traffic
// - per-lane sync keeps running during alignment and normal operation
// - per-lane sync follows the gigabit 8b/10b acquire and lose diagram
package ls_align_pkg;
	localparam int LANES = 4;
	localparam logic [5:0] PAT_LAST = 6'h30; // 49 characters, positions 0..48
	localparam logic [3:0] GROUP_LAST = 4'hb; // twelve data characters
	localparam logic [95:0] PAT_DATA = {8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
		8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
	localparam logic [7:0] COMMA_CHAR = 8'hbc;
	localparam logic [9:0] COMMA_RDN = 10'h0fa;
	localparam logic [9:0] COMMA_RDP = 10'h305;
	localparam logic [6:0] COMMA_POS7 = 7'h1f;
	localparam logic [6:0] COMMA_NEG7 = 7'h60;
	localparam logic [2:0] COMMA_ACQ_LAST = 3'h2; // third comma acquires
	localparam logic [2:0] BAD_LOSE_LAST = 3'h3; // fourth net invalid loses
	localparam logic [2:0] GOOD_RECOV_LAST = 3'h3; // four good groups repay one invalid
	localparam logic [2:0] DSK_MAX = 3'h7;
	localparam logic [3:0] MASK_WIDE = 4'hf;
	localparam logic [3:0] MASK_NARROW = 4'h3;

	typedef struct packed {
		logic ctl;
		logic [7:0] data;
	} tx_char_s;

	typedef struct packed {
		logic link_good_in;
		logic pll_lock;
		logic restart;
		logic [3:0] los;
	} pin_s;

	typedef enum logic [2:0] {SY_LOSS = 3'b001, SY_COMMA = 3'b010, SY_ACQ = 3'b100} sync_e;
	typedef enum logic [2:0] {DK_IDLE = 3'b001, DK_WAIT = 3'b010, DK_DONE = 3'b100} dsk_e;
endpackage : ls_align_pkg

// *** verilog/ls_lane_alignment_sync.sv ***
`timescale 1ns/1ns
module ls_lane_alignment_sync
	import ls_align_pkg::*;
(
	input wire logic clock, // 25 MHz character clock
	input wire logic rst_n, // async reset, active low
	input wire logic wide_mode, // 1: four lanes, 0: two lanes
	input wire tx_char_s [LANES-1:0] hs_char, // traffic from high-speed side
	input wire pin_s pins_raw, // asynchronous pin inputs
	input wire logic [LANES-1:0][9:0] rx_sym, // raw deserialised words, msb first
	output logic [LANES-1:0][9:0] tx_sym, // encoded words per lane
	output logic tx_pattern_active, // alignment pattern being sent
	output logic lane_link_good_out, // receive alignment complete
	output logic [LANES-1:0][9:0] rx_data, // rotated and deskewed words
	output logic [LANES-1:0] rx_lane_sync // per-lane sync acquired
);
	function automatic logic [10:0] enc_8b10b(input tx_char_s c, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic rd6;
		logic [4:0] x;
		logic [2:0] y;
		x = c.data[4:0];
		y = c.data[7:5];
		c6 = 6'h00;
		c4 = 4'h0;
		if (c.ctl) begin
			// only the comma control character is produced; it flips disparity
			return {!rd, (rd ? COMMA_RDP : COMMA_RDN)};
		end
		case (x)
			5'd0: c6 = 6'b100111; 5'd1: c6 = 6'b011101; 5'd2: c6 = 6'b101101;
			5'd3: c6 = 6'b110001; 5'd4: c6 = 6'b110101; 5'd5: c6 = 6'b101001;
			5'd6: c6 = 6'b011001; 5'd7: c6 = 6'b111000; 5'd8: c6 = 6'b111001;
			5'd9: c6 = 6'b100101; 5'd10: c6 = 6'b010101; 5'd11: c6 = 6'b110100;
			5'd12: c6 = 6'b001101; 5'd13: c6 = 6'b101100; 5'd14: c6 = 6'b011100;
			5'd15: c6 = 6'b010111; 5'd16: c6 = 6'b011011; 5'd17: c6 = 6'b100011;
			5'd18: c6 = 6'b010011; 5'd19: c6 = 6'b110010; 5'd20: c6 = 6'b001011;
			5'd21: c6 = 6'b101010; 5'd22: c6 = 6'b011010; 5'd23: c6 = 6'b111010;
			5'd24: c6 = 6'b110011; 5'd25: c6 = 6'b100110; 5'd26: c6 = 6'b010110;
			5'd27: c6 = 6'b110110; 5'd28: c6 = 6'b001110; 5'd29: c6 = 6'b101110;
			5'd30: c6 = 6'b011110; default: c6 = 6'b101011;
		endcase
		if (rd && (($countones(c6) != 3) || (x == 5'd7))) begin
			c6 = ~c6;
		end
		rd6 = rd ^ ($countones(c6) != 3);
		case (y)
			3'd0: c4 = 4'b1011; 3'd1: c4 = 4'b1001; 3'd2: c4 = 4'b0101;
			3'd3: c4 = 4'b1100; 3'd4: c4 = 4'b1101; 3'd5: c4 = 4'b1010;
			3'd6: c4 = 4'b0110; default: c4 = 4'b1110;
		endcase
		if ((y == 3'd7) && ((!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
				|| (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)))) begin
			c4 = 4'b0111;
		end
		if (rd6 && (($countones(c4) != 2) || (y == 3'd3))) begin
			c4 = ~c4;
		end
		return {rd6 ^ ($countones(c4) != 2), c6, c4};
	endfunction : enc_8b10b

	function automatic logic [9:0] pick_word(input logic [19:0] win, input logic [3:0] r);
		logic [9:0] w;
		w = win[19:10];
		for (int i = 1; i < 10; i++) begin
			if (r == 4'(i)) begin
				w = win[19-i -: 10];
			end
		end
		return w;
	endfunction : pick_word

	function automatic logic [4:0] find_comma(input logic [19:0] win);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 9; i >= 0; i--) begin
			if (win[19-i -: 7] == COMMA_POS7 || win[19-i -: 7] == COMMA_NEG7) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction : find_comma

	function automatic logic is_comma(input logic [9:0] s);
		return (s[9:3] == COMMA_POS7) || (s[9:3] == COMMA_NEG7);
	endfunction : is_comma

	function automatic logic cg_valid(input logic [9:0] s);
		return ($countones(s) >= 4) && ($countones(s) <= 6)
			&& (s[9:4] != 6'h00) && (s[9:4] != 6'h3f);
	endfunction : cg_valid

	// pin synchronisers: a change counts when stages two and three agree
	logic [6:0] ps1_reg, ps2_reg, ps3_reg, pst_reg, pst_next;
	pin_s pins;
	logic wide_reg;
	logic [3:0] act;
	logic link_ok, link_ok_reg, config_chg, restart_ev, all_acq;

	assign pins = pin_s'(pst_reg);
	assign act = wide_mode ? MASK_WIDE : MASK_NARROW;
	assign link_ok = pins.link_good_in;
	assign config_chg = wide_mode != wide_reg;

	always_comb begin
		pst_next = (~(ps2_reg ^ ps3_reg) & ps3_reg) | ((ps2_reg ^ ps3_reg) & pst_reg);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ps1_reg <= 7'h00;
			ps2_reg <= 7'h00;
			ps3_reg <= 7'h00;
			pst_reg <= 7'h00;
			wide_reg <= 1'b0;
			link_ok_reg <= 1'b0;
		end else begin
			ps1_reg <= pins_raw;
			ps2_reg <= ps1_reg;
			ps3_reg <= ps2_reg;
			pst_reg <= pst_next;
			wide_reg <= wide_mode;
			link_ok_reg <= link_ok;
		end
	end

	// alignment pattern sender
	logic [5:0] pat_pos_reg, pat_pos_next;
	logic [3:0] grp_reg, grp_next;
	logic [LANES-1:0] rd_reg, rd_next;
	logic [LANES-1:0][9:0] tx_sym_reg, tx_sym_next;
	logic tx_act_reg;
	tx_char_s ch;
	logic [10:0] enc;

	always_comb begin
		pat_pos_next = (pat_pos_reg == PAT_LAST) ? 6'h00 : pat_pos_reg + 6'h01;
		grp_next = grp_reg;
		if (pat_pos_reg != 6'h00) begin
			grp_next = (grp_reg == GROUP_LAST) ? 4'h0 : grp_reg + 4'h1;
		end
		if (link_ok || (link_ok_reg && !link_ok) || restart_ev) begin
			pat_pos_next = 6'h00;
			grp_next = 4'h0;
		end
		rd_next = rd_reg;
		tx_sym_next = '0;
		ch = '0;
		enc = '0;
		for (int l = 0; l < LANES; l++) begin
			if (link_ok) begin
				ch = hs_char[l];
			end else if (pat_pos_reg == 6'h00) begin
				ch = '{ctl: 1'b1, data: COMMA_CHAR};
			end else begin
				ch = '{ctl: 1'b0, data: PAT_DATA[95 - 8*grp_reg -: 8]};
			end
			enc = enc_8b10b(ch, rd_reg[l]);
			if (act[l]) begin
				tx_sym_next[l] = enc[9:0];
				rd_next[l] = enc[10];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pat_pos_reg <= 6'h00;
			grp_reg <= 4'h0;
			rd_reg <= '0;
			tx_sym_reg <= '0;
			tx_act_reg <= 1'b0;
		end else begin
			pat_pos_reg <= pat_pos_next;
			grp_reg <= grp_next;
			rd_reg <= rd_next;
			tx_sym_reg <= tx_sym_next;
			tx_act_reg <= !link_ok;
		end
	end

	// per-lane character synchronisation
	sync_e sy_reg [LANES];
	sync_e sy_next [LANES];
	logic [LANES-1:0][9:0] prev_reg, prev_next, al_reg, al_next;
	logic [LANES-1:0][3:0] rot_reg, rot_next;
	logic [LANES-1:0][2:0] cnt_reg, cnt_next, good_reg, good_next;
	logic [LANES-1:0] sync_out_next;
	logic [19:0] win;
	logic [4:0] fc;
	logic [9:0] cand;

	always_comb begin
		win = '0;
		fc = '0;
		cand = '0;
		for (int l = 0; l < LANES; l++) begin
			win = {prev_reg[l], rx_sym[l]};
			fc = find_comma(win);
			cand = pick_word(win, rot_reg[l]);
			prev_next[l] = rx_sym[l];
			al_next[l] = cand;
			rot_next[l] = rot_reg[l];
			cnt_next[l] = cnt_reg[l];
			good_next[l] = good_reg[l];
			sy_next[l] = sy_reg[l];
			case (sy_reg[l])
				SY_LOSS: begin
					if (fc[4]) begin
						rot_next[l] = fc[3:0];
						al_next[l] = pick_word(win, fc[3:0]);
						cnt_next[l] = 3'h0;
						sy_next[l] = SY_COMMA;
					end
				end
				SY_COMMA: begin
					if (!cg_valid(cand)) begin
						sy_next[l] = SY_LOSS;
					end else if (is_comma(cand)) begin
						cnt_next[l] = cnt_reg[l] + 3'h1;
						if (cnt_reg[l] == COMMA_ACQ_LAST - 3'h1) begin
							sy_next[l] = SY_ACQ;
							cnt_next[l] = 3'h0;
							good_next[l] = 3'h0;
						end
					end
				end
				SY_ACQ: begin
					if (!cg_valid(cand)) begin
						good_next[l] = 3'h0;
						cnt_next[l] = cnt_reg[l] + 3'h1;
						if (cnt_reg[l] == BAD_LOSE_LAST) begin
							sy_next[l] = SY_LOSS;
						end
					end else if (cnt_reg[l] != 3'h0) begin
						good_next[l] = good_reg[l] + 3'h1;
						if (good_reg[l] == GOOD_RECOV_LAST) begin
							good_next[l] = 3'h0;
							cnt_next[l] = cnt_reg[l] - 3'h1;
						end
					end
				end
				default: sy_next[l] = SY_LOSS;
			endcase
			if (pins.los[l] || restart_ev || !act[l]) begin
				sy_next[l] = SY_LOSS;
			end
			sync_out_next[l] = sy_next[l] == SY_ACQ;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
			al_reg <= '0;
			rot_reg <= '0;
			cnt_reg <= '0;
			good_reg <= '0;
			rx_lane_sync <= '0;
			for (int l = 0; l < LANES; l++) begin
				sy_reg[l] <= SY_LOSS;
			end
		end else begin
			prev_reg <= prev_next;
			al_reg <= al_next;
			rot_reg <= rot_next;
			cnt_reg <= cnt_next;
			good_reg <= good_next;
			rx_lane_sync <= sync_out_next;
			sy_reg <= sy_next;
		end
	end

	// lane deskew on the comma marker
	dsk_e dk_reg, dk_next;
	logic [9:0] dl_reg [LANES][8];
	logic [9:0] dl_next [LANES][8];
	logic [LANES-1:0][2:0] tap_reg, tap_next;
	logic [LANES-1:0] seen_reg, seen_next;
	logic [2:0] wcnt_reg, wcnt_next;
	logic [LANES-1:0][9:0] rx_data_next;
	logic good_out_next;

	always_comb begin
		all_acq = 1'b1;
		for (int l = 0; l < LANES; l++) begin
			all_acq = all_acq & (!act[l] || sy_reg[l] == SY_ACQ);
		end
		restart_ev = pins.restart || !pins.pll_lock || config_chg
			|| |(pins.los & act);
	end

	always_comb begin
		dk_next = dk_reg;
		tap_next = tap_reg;
		seen_next = seen_reg;
		wcnt_next = wcnt_reg;
		for (int l = 0; l < LANES; l++) begin
			dl_next[l][0] = al_reg[l];
			for (int k = 1; k < 8; k++) begin
				dl_next[l][k] = dl_reg[l][k-1];
			end
		end
		case (dk_reg)
			DK_IDLE: begin
				seen_next = '0;
				tap_next = '0;
				wcnt_next = 3'h0;
				if (all_acq) begin
					dk_next = DK_WAIT;
				end
			end
			DK_WAIT: begin
				for (int l = 0; l < LANES; l++) begin
					if (act[l] && seen_reg[l]) begin
						tap_next[l] = tap_reg[l] + 3'h1;
					end else if (act[l] && is_comma(al_reg[l])) begin
						seen_next[l] = 1'b1;
						tap_next[l] = 3'h0;
					end
				end
				if (seen_reg != '0) begin
					wcnt_next = wcnt_reg + 3'h1;
				end
				if ((seen_next & act) == act) begin
					dk_next = DK_DONE;
				end else if (wcnt_reg == DSK_MAX) begin
					dk_next = DK_IDLE;
				end
				if (!all_acq) begin
					dk_next = DK_IDLE;
				end
			end
			DK_DONE: begin
				if (!all_acq) begin
					dk_next = DK_IDLE;
				end
			end
			default: dk_next = DK_IDLE;
		endcase
		if (restart_ev) begin
			dk_next = DK_IDLE;
		end
		good_out_next = dk_next == DK_DONE;
		// new taps already, so words are aligned as link good rises
		for (int l = 0; l < LANES; l++) begin
			rx_data_next[l] = dl_reg[l][tap_next[l]];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dk_reg <= DK_IDLE;
			tap_reg <= '0;
			seen_reg <= '0;
			wcnt_reg <= 3'h0;
			rx_data <= '0;
			lane_link_good_out <= 1'b0;
			for (int l = 0; l < LANES; l++) begin
				for (int k = 0; k < 8; k++) begin
					dl_reg[l][k] <= 10'h000;
				end
			end
		end else begin
			dk_reg <= dk_next;
			tap_reg <= tap_next;
			seen_reg <= seen_next;
			wcnt_reg <= wcnt_next;
			rx_data <= rx_data_next;
			lane_link_good_out <= good_out_next;
			dl_reg <= dl_next;
		end
	end

	assign tx_sym = tx_sym_reg;
	assign tx_pattern_active = tx_act_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence pat_wrap_s;
		(!link_ok && !restart_ev && pat_pos_reg == PAT_LAST) ##1 (!link_ok && !restart_ev);
	endsequence
	sequence lane0_fourth_bad_s;
		sy_reg[0] == SY_ACQ && cnt_reg[0] == BAD_LOSE_LAST && !cg_valid(al_next[0]);
	endsequence

	AST_GOOD_NEEDS_SYNC: assert property (lane_link_good_out |-> $past(all_acq))
		else $error("link good without all lanes in sync");
	AST_COMMA_HEADS_PERIOD: assert property (pat_wrap_s |=> is_comma(tx_sym[0]))
		else $error("pattern period does not start with comma");
	AST_PERIOD_LEN: assert property (pat_pos_reg <= PAT_LAST)
		else $error("pattern position beyond period");
	AST_GROUP_ORDER: assert property ((!link_ok && pat_pos_reg == 6'h0d) |-> grp_reg == 4'h0)
		else $error("data group out of step");
	AST_FORWARD: assert property ($rose(link_ok) |=> !tx_pattern_active)
		else $error("pattern still active after link good");
	AST_LOSE_SYNC: assert property (lane0_fourth_bad_s |=> sy_reg[0] == SY_LOSS)
		else $error("lane kept sync after fourth invalid group");
	AST_ACQ_VIA_COMMA: assert property ($rose(rx_lane_sync[0])
		|-> $past(sy_reg[0] == SY_COMMA))
		else $error("sync acquired without comma detection");
	AST_RESTART: assert property (restart_ev |=> !lane_link_good_out)
		else $error("link good held across restart");
	AST_NO_RECHECK: assert property ((dk_reg == DK_DONE && all_acq && !restart_ev)
		|=> dk_reg == DK_DONE)
		else $error("alignment dropped without cause");
endmodule : ls_lane_alignment_sync

// *** tb/link_partner_model.sv ***
`timescale 1ns/1ns
module link_partner_model
	import ls_align_pkg::*;
(
	input wire logic clock, // character clock
	input wire logic rst_n, // async reset, active low
	input wire logic [LANES-1:0][9:0] tx_sym, // words from device
	input wire logic tie_high, // hold link good high
	input wire logic [LANES-1:0][2:0] skew, // lane offset in words
	input wire logic [LANES-1:0][3:0] rot, // bit slip per lane
	input wire logic [LANES-1:0] bad, // send an invalid word
	output logic [LANES-1:0][9:0] rx_sym, // words to device
	output logic link_good_in // partner aligned
);
	logic [2:0] cnt_reg;
	logic [1:0] seen_reg;
	logic k_now, k_reg;
	logic [LANES-1:0] rd_reg;
	logic [LANES-1:0][9:0] cur;
	logic [LANES-1:0][9:0] prev_reg;
	logic [19:0] two;
	assign k_now = tx_sym[0] == COMMA_RDN || tx_sym[0] == COMMA_RDP;
	// comma every eight words, neutral data between
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			if (bad[i])
				cur[i] = 10'h000;
			else if (3'(cnt_reg + skew[i]) == 3'h0)
				cur[i] = rd_reg[i] ? COMMA_RDP : COMMA_RDN;
			else
				cur[i] = 10'h2aa;
			two = {prev_reg[i], cur[i]} >> rot[i];
			rx_sym[i] = two[9:0];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 3'h0;
			seen_reg <= 2'h0;
			k_reg <= 1'b0;
			rd_reg <= '0;
			prev_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
			prev_reg <= cur;
			for (int i = 0; i < LANES; i++) begin
				if (cur[i] == COMMA_RDN || cur[i] == COMMA_RDP)
					rd_reg[i] <= !rd_reg[i];
			end
			k_reg <= k_now;
			// a pattern head is a comma followed by data; aligned after the third
			if (seen_reg != 2'h3 && k_reg && !k_now)
				seen_reg <= seen_reg + 2'h1;
		end
	end
	assign link_good_in = tie_high || seen_reg == 2'h3;
endmodule : link_partner_model

// *** tb/ls_lane_alignment_sync_test.sv ***
`timescale 1ns/1ns
module ls_lane_alignment_sync_test;
	import ls_align_pkg::*;
	logic clock, rst_n, wide_mode, lgi, pll, rpin, tie_high, tx_pattern_active, lgo;
	logic [3:0] los;
	logic [LANES-1:0] bad, rx_lane_sync;
	logic [LANES-1:0][2:0] skew;
	logic [LANES-1:0][3:0] rot;
	logic [LANES-1:0][9:0] rx_sym, tx_sym, rx_data;
	tx_char_s [LANES-1:0] hs_char;
	pin_s pins;
	int mismatches, comparisons;
	assign pins = {lgi, pll, rpin, los};
	ls_lane_alignment_sync uut (.clock(clock), .rst_n(rst_n), .wide_mode(wide_mode),
		.hs_char(hs_char), .pins_raw(pins), .rx_sym(rx_sym), .tx_sym(tx_sym),
		.tx_pattern_active(tx_pattern_active), .lane_link_good_out(lgo),
		.rx_data(rx_data), .rx_lane_sync(rx_lane_sync));
	link_partner_model partner (.clock(clock), .rst_n(rst_n), .tx_sym(tx_sym),
		.tie_high(tie_high), .skew(skew), .rot(rot), .bad(bad), .rx_sym(rx_sym),
		.link_good_in(lgi));
	task automatic wrap_up();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	function automatic logic is_k(input logic [9:0] w);
		return w === COMMA_RDN || w === COMMA_RDP;
	endfunction : is_k
	// same code group, either disparity form
	function automatic logic same(input logic [9:0] a, input logic [9:0] b);
		return (a[9:4] === b[9:4] || a[9:4] === ~b[9:4])
			&& (a[3:0] === b[3:0] || a[3:0] === ~b[3:0]);
	endfunction : same
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#5;
	endtask : tick
	task automatic do_reset();
		rst_n = 1'b0;
		tick(12);
		rst_n = 1'b1;
		tick(6);
	endtask : do_reset
	task automatic wait_good();
		int n;
		n = 0;
		while (lgo !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		check(lgo, 1'b1);
	endtask : wait_good
	task automatic t_pattern(input logic w);
		logic [9:0] q [49];
		int n;
		wide_mode = w;
		do_reset();
		n = 0;
		while (!is_k(tx_sym[0]) && n < 100) begin
			tick(1);
			n++;
		end
		check(tx_pattern_active, 1'b1);
		for (int k = 0; k < 49; k++) begin
			q[k] = tx_sym[0];
			check(tx_sym[1], q[k]);
			check(tx_sym[3], w ? q[k] : 10'h000);
			tick(1);
		end
		check(is_k(q[0]) && is_k(tx_sym[0]), 1'b1);
		check(q[1], q[0] === COMMA_RDN ? 10'h21a : 10'h1ea);
		for (int k = 1; k < 37; k++)
			check(same(q[k], q[k + 12]) && !is_k(q[k]), 1'b1);
		tick(8);
		check(tx_pattern_active, 1'b0);
		check(is_k(tx_sym[0]) && is_k(tx_sym[1]), 1'b1);
		$display("pattern test done");
	endtask : t_pattern
	task automatic t_tie();
		tie_high = 1'b1;
		do_reset();
		for (int k = 0; k < 60; k++) begin
			check(tx_pattern_active, 1'b0);
			tick(1);
		end
		tie_high = 1'b0;
		$display("tie test done");
	endtask : t_tie
	task automatic t_rx(input logic w);
		wide_mode = w;
		skew = {3'h0, 3'h2, 3'h1, 3'h3};
		do_reset();
		wait_good();
		check(rx_lane_sync, w ? 4'hf : 4'h3);
		for (int k = 0; k < 16; k++) begin
			check(is_k(rx_data[0]) || rx_data[0] === 10'h2aa, 1'b1);
			for (int i = 1; i < (w ? 4 : 2); i++)
				check(is_k(rx_data[i]), is_k(rx_data[0]));
			tick(1);
		end
		skew[1] = 3'h4;
		tick(30);
		check(lgo, 1'b1);
		check(rx_lane_sync, w ? 4'hf : 4'h3);
		$display("receive test done");
	endtask : t_rx
	task automatic t_events();
		for (int e = 0; e < 3; e++) begin
			los[2] = e == 0;
			pll = e != 1;
			rpin = e == 2;
			tick(8);
			check(lgo, 1'b0);
			los = 4'h0;
			pll = 1'b1;
			rpin = 1'b0;
			wait_good();
		end
		$display("restart test done");
	endtask : t_events
	task automatic t_bad();
		bad[0] = 1'b1;
		tick(3);
		bad[0] = 1'b0;
		tick(10);
		check(rx_lane_sync[0], 1'b1);
		check(lgo, 1'b1);
		bad[0] = 1'b1;
		tick(4);
		bad[0] = 1'b0;
		tick(3);
		check(rx_lane_sync[0], 1'b0);
		check(lgo, 1'b0);
		wait_good();
		$display("invalid word test done");
	endtask : t_bad
	initial begin
		clock = 1'b0;
		forever #20 clock = !clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		wide_mode = 1'b1;
		hs_char = {LANES{9'h100}};
		pll = 1'b1;
		rpin = 1'b0;
		los = 4'h0;
		tie_high = 1'b0;
		skew = '0;
		rot = {4'h5, 4'h7, 4'h3, 4'h0};
		bad = '0;
		mismatches = 0;
		comparisons = 0;
		t_pattern(1'b1);
		t_pattern(1'b0);
		t_tie();
		t_rx(1'b0);
		t_rx(1'b1);
		t_events();
		t_bad();
		wrap_up();
	end
endmodule : ls_lane_alignment_sync_test
